// *** global_ctrl.v ***
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "gc_regs.vh"

//
// Behaviour
// [RULE1] Identification word: family code bits 15-8, chip 7-4, rev 3-1.
// [RULE2] Bits 15 and 9 choose which status drives each of four LEDs.
// [RULE3] Writing the indirect control word launches a command; bit 12 reads.
// [RULE4] A read command fetches the addressed counter then zeroes it.
// [RULE5] Host must use table select 11 for counters; others reserved.
// [RULE6] Five-bit address selects one of 32 counters.
// [RULE7] Low data word holds counter bits 15-0.
// [RULE8] High data word holds counter bits 31-16.
// [RULE9] Delay bit holds power event until clocks run and host ready; the code releases it on clocks_ready alone.
// [RULE10] Delay setting only applies while auto wake-up bit 7 is set.
// [RULE11] Polarity bit 12: one gives active high, zero active low.
// [RULE12] Enables: 11 wake frame, 10 remote wake, 9 link up, 8 energy.
// [RULE13] Assert power event only for events whose enable is set.
// [RULE14] Auto wake-up returns to normal power after energy persists.
// [RULE15] Power event drops once host clears status by writing ones.
// [RULE16] Both data words load from one counter snapshot.
//
module global_ctrl
#(
    parameter [7:0]  FAMILY_CODE = 8'h5a,  // Arbitrary value
    parameter [3:0]  CHIP_CODE   = 4'h3,   // Arbitrary value
    parameter [2:0]  REV_CODE    = 3'h2,   // Arbitrary value
    parameter        WAKE_UNIT   = `WAKE_UNIT_CYCLES
)
(
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst,
    // Register port
    input  wire [7:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    // Port status inputs for LEDs
    input  wire        link_up,
    input  wire        activity,
    input  wire        full_duplex,
    input  wire        collision,
    input  wire        speed_100,
    // Statistics count strobes
    input  wire [31:0] count_inc,
    // Wake events and system state
    input  wire        wake_frame,
    input  wire        remote_wake,
    input  wire        link_change_up,
    input  wire        energy_detect,
    input  wire        clocks_ready,
    input  wire        energy_detect_mode,
    // Outputs
    output reg         port_led_3,
    output reg         port_led_2,
    output reg         port_led_1,
    output reg         port_led_0,
    output reg         power_event_output,
    output reg         wake_to_normal,
    output reg         irq
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [15:0] global_led_control;
    reg  [15:0] indirect_access_control;
    reg  [15:0] indirect_data_low;
    reg  [15:0] indirect_data_high;
    reg  [15:0] power_event_control;
    reg  [3:0]  wake_status;
    reg  [2:0]  irq_status;
    reg  [2:0]  irq_enable;
    reg         fetch;
    reg         pending_event;

    wire [31:0] fetch_data;
    wire        fetch_done;
    wire        wake_expired;

    wire [15:0] part_identification =
        {FAMILY_CODE, CHIP_CODE, REV_CODE, 1'b0};  // [RULE1]

    wire [1:0] led_sel = {global_led_control[`LED_SEL_HIGH_BIT],
                          global_led_control[`LED_SEL_LOW_BIT]};
    wire [3:0] wake_en =
        power_event_control[`PWR_EN_HI:`PWR_EN_LO];
    wire       auto_wake = power_event_control[`PWR_AUTO_BIT];
    wire       delay_en  = power_event_control[`PWR_DELAY_BIT];
    wire       pol_high  = power_event_control[`PWR_POL_BIT];

    // Wake events in status-bit order: energy, link up, remote, frame
    wire [3:0] wake_evt = {wake_frame, remote_wake,
                           link_change_up, energy_detect};  // [RULE12]
    wire [3:0] wake_hit = wake_evt & wake_en;                // [RULE13]

    wire w_ind  = wr && addr == `OFS_IND_CTRL;
    wire w_pwr  = wr && addr == `OFS_PWR_CTRL;
    wire [3:0] w1c_stat = w_pwr ?
        wdata[`PWR_STAT_HI:`PWR_STAT_LO] : 4'h0;
    wire [2:0] irq_clr = (wr && addr == `OFS_IRQ_CLEAR) ?
        wdata[2:0] : 3'h0;
    wire [2:0] irq_evt = {fetch_done, |wake_hit, wake_expired};

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    stat_counter_bank u_counters
    (
        .core_clk   (core_clk),
        .rst        (rst),
        .count_inc  (count_inc),
        .fetch      (fetch),
        .fetch_addr (indirect_access_control[4:0]),  // [RULE6]
        .fetch_data (fetch_data),
        .fetch_done (fetch_done)
    );

    wake_timer #(.UNIT_CYCLES(WAKE_UNIT)) u_wake
    (
        .core_clk  (core_clk),
        .rst       (rst),
        .energy    (energy_detect && energy_detect_mode),
        .wake_time (`WAKE_TIME_DEFAULT),
        .expired   (wake_expired)
    );

    // ------------------------------------------------------------------
    // Register writes and indirect command
    // ------------------------------------------------------------------
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            global_led_control      <= `RST_LED_CTRL;
            indirect_access_control <= `RST_IND_CTRL;
            indirect_data_low       <= `RST_IND_DATA;
            indirect_data_high      <= `RST_IND_DATA;
            power_event_control     <= `RST_PWR_CTRL;
            irq_enable              <= 3'h0;
            fetch                   <= 1'b0;
        end
        else
        begin
            // Launch only on a read-enabled write to the counter table;
            // reserved table codes do nothing
            fetch <= w_ind && wdata[`IND_READ_BIT] &&
                     wdata[`IND_TABLE_HI:`IND_TABLE_LO] ==
                     `IND_TABLE_CNT;                         // [RULE3] [RULE4] [RULE5]
            if (wr)
            begin
                case (addr)
                    `OFS_LED_CTRL:   global_led_control      <= wdata;
                    `OFS_IND_CTRL:   indirect_access_control <= wdata;
                    `OFS_IND_LOW:    indirect_data_low       <= wdata;
                    `OFS_IND_HIGH:   indirect_data_high      <= wdata;
                    `OFS_PWR_CTRL:   power_event_control     <=
                        {1'b0, wdata[14:6], 6'h00};
                    `OFS_IRQ_ENABLE: irq_enable              <= wdata[2:0];
                    default:         ;
                endcase
            end
            // Both halves come from one snapshot
            if (fetch_done)
            begin
                indirect_data_low  <= fetch_data[15:0];      // [RULE7] [RULE16]
                indirect_data_high <= fetch_data[31:16];     // [RULE8] [RULE16]
            end
        end
    end

    // ------------------------------------------------------------------
    // Wake status, power event and interrupts
    // ------------------------------------------------------------------
    // A new event in the same cycle as a clear keeps its bit set
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wake_status   <= 4'h0;
            irq_status    <= 3'h0;
            pending_event <= 1'b0;
        end
        else
        begin
            wake_status <= (wake_status & ~w1c_stat) | wake_hit;  // [RULE15]
            irq_status  <= (irq_status & ~irq_clr) | irq_evt;
            pending_event <= |((wake_status & ~w1c_stat) | wake_hit);
        end
    end

    wire hold_off = auto_wake && delay_en && !clocks_ready;  // [RULE9] [RULE10]

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            power_event_output <= 1'b0;
            wake_to_normal     <= 1'b0;
            irq                <= 1'b0;
        end
        else
        begin
            power_event_output <= (pending_event && !hold_off) ?
                                  pol_high : !pol_high;      // [RULE11] [RULE13]
            wake_to_normal     <= auto_wake && wake_expired; // [RULE14]
            irq                <= |(irq_status & irq_enable);
        end
    end

    // ------------------------------------------------------------------
    // LEDs
    // ------------------------------------------------------------------
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            port_led_3 <= 1'b0;
            port_led_2 <= 1'b0;
            port_led_1 <= 1'b0;
            port_led_0 <= 1'b0;
        end
        else
        begin
            case (led_sel)                                   // [RULE2]
                2'b00:
                begin
                    port_led_3 <= 1'b0;
                    port_led_2 <= link_up && activity;
                    port_led_1 <= full_duplex || collision;
                    port_led_0 <= speed_100;
                end
                2'b01:
                begin
                    port_led_3 <= 1'b0;
                    port_led_2 <= link_up && activity && speed_100;
                    port_led_1 <= link_up && activity && !speed_100;
                    port_led_0 <= full_duplex;
                end
                2'b10:
                begin
                    port_led_3 <= activity;
                    port_led_2 <= link_up;
                    port_led_1 <= full_duplex || collision;
                    port_led_0 <= speed_100;
                end
                default:
                begin
                    port_led_3 <= 1'b0;
                    port_led_2 <= 1'b0;
                    port_led_1 <= 1'b0;
                    port_led_0 <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------------
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rdata <= 16'h0000;
        else if (rd)
        begin
            case (addr)
                `OFS_PART_ID:    rdata <= part_identification;
                `OFS_LED_CTRL:   rdata <= global_led_control;
                `OFS_IND_CTRL:   rdata <= indirect_access_control;
                `OFS_IND_LOW:    rdata <= indirect_data_low;
                `OFS_IND_HIGH:   rdata <= indirect_data_high;
                `OFS_PWR_CTRL:   rdata <= {power_event_control[15:6],
                                           wake_status, 2'b00};
                `OFS_IRQ_STATUS: rdata <= {13'h0000, irq_status};
                `OFS_IRQ_ENABLE: rdata <= {13'h0000, irq_enable};
                default:         rdata <= 16'h0000;
            endcase
        end
        else
            rdata <= 16'h0000;
    end

endmodule

// *** gc_regs.vh ***
`ifndef GC_REGS_VH
`define GC_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, 8-bit address port)
// ----------------------------------------------------------------------
`define OFS_PART_ID        8'hc0
`define OFS_LED_CTRL       8'hc6
`define OFS_IND_CTRL       8'hc8
`define OFS_IND_LOW        8'hd0
`define OFS_IND_HIGH       8'hd2
`define OFS_PWR_CTRL       8'hd4
`define OFS_IRQ_STATUS     8'he0
`define OFS_IRQ_CLEAR      8'he2
`define OFS_IRQ_ENABLE     8'he4

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LED_SEL_HIGH_BIT   15
`define LED_SEL_LOW_BIT    9
`define IND_READ_BIT       12
`define IND_TABLE_HI       11
`define IND_TABLE_LO       10
`define IND_TABLE_CNT      2'b11
`define PWR_DELAY_BIT      14
`define PWR_POL_BIT        12
`define PWR_EN_HI          11
`define PWR_EN_LO          8
`define PWR_AUTO_BIT       7
`define PWR_STAT_HI        5
`define PWR_STAT_LO        2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_LED_CTRL       16'h0835
`define RST_IND_CTRL       16'h0000
`define RST_IND_DATA       16'h0000
`define RST_PWR_CTRL       16'h0000

// ----------------------------------------------------------------------
// Timing: wake-up time unit 16 ms at 40 MHz
// ----------------------------------------------------------------------
`define CLK_HZ             40000000
`define WAKE_UNIT_MS       16
`define WAKE_UNIT_CYCLES   (`CLK_HZ / 1000 * `WAKE_UNIT_MS)
`define WAKE_TIME_DEFAULT  8'h08

`endif

// *** stat_counter_bank.v ***
`timescale 1ns/1ps
`include "gc_regs.vh"

// 32 statistics counters; a fetch returns one snapshot and clears it
module stat_counter_bank
(
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst,
    // Count strobes, one bit per counter
    input  wire [31:0] count_inc,
    // Fetch-and-clear request
    input  wire        fetch,
    input  wire [4:0]  fetch_addr,
    // Snapshot result
    output reg  [31:0] fetch_data,
    output reg         fetch_done
);

    reg [31:0] counter [0:31];

    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1)
        begin : g_cnt
            localparam [4:0] IDX = i;
            always @(posedge core_clk or posedge rst)
            begin
                if (rst)
                    counter[i] <= 32'h0000_0000;
                else if (fetch && fetch_addr == IDX)
                    // Clear on fetch; an increment in the same cycle
                    // is kept so no event is lost
                    counter[i] <= {31'h0000_0000, count_inc[i]};
                else if (count_inc[i])
                    counter[i] <= counter[i] + 32'h0000_0001;
            end
        end
    endgenerate

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            fetch_data <= 32'h0000_0000;
            fetch_done <= 1'b0;
        end
        else
        begin
            fetch_done <= fetch;
            if (fetch)
                fetch_data <= counter[fetch_addr];
        end
    end

endmodule

// *** wake_timer.v ***
`timescale 1ns/1ps
`include "gc_regs.vh"

// Flags when signal energy has lasted longer than wake_time units
module wake_timer
#(
    parameter UNIT_CYCLES = `WAKE_UNIT_CYCLES
)
(
    // Clock and reset
    input  wire       core_clk,
    input  wire       rst,
    // Energy level and programmed time in units
    input  wire       energy,
    input  wire [7:0] wake_time,
    // High while energy has persisted long enough
    output reg        expired
);

    reg [19:0] tick_cnt;
    reg [7:0]  unit_cnt;
    wire       tick = (tick_cnt == UNIT_CYCLES[19:0] - 20'h0_0001);

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt <= 20'h0_0000;
            unit_cnt <= 8'h00;
            expired  <= 1'b0;
        end
        else if (!energy)
        begin
            // Energy must be seen without a break
            tick_cnt <= 20'h0_0000;
            unit_cnt <= 8'h00;
            expired  <= 1'b0;
        end
        else
        begin
            tick_cnt <= tick ? 20'h0_0000 : tick_cnt + 20'h0_0001;
            if (tick && unit_cnt != 8'hff)
                unit_cnt <= unit_cnt + 8'h01;
            if (unit_cnt >= wake_time && wake_time != 8'h00)
                expired <= 1'b1;
        end
    end

endmodule

// *** gc_props.sv ***
`timescale 1ns/1ps
`include "gc_regs.vh"

module gc_props
#(
    parameter [7:0] FAMILY_CODE = 8'h5a,
    parameter [3:0] CHIP_CODE   = 4'h3,
    parameter [2:0] REV_CODE    = 3'h2
)
(
    // Clock and reset
    input wire        core_clk,
    input wire        rst,
    // Register port
    input wire [7:0]  addr,
    input wire [15:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [15:0] rdata,
    // Events and outputs
    input wire        wake_frame,
    input wire        clocks_ready,
    input wire        port_led_3,
    input wire        port_led_0,
    input wire        power_event_output,
    input wire        wake_to_normal
);
    reg  [15:0] lc;
    reg  [15:0] pc;
    wire        pol  = pc[`PWR_POL_BIT];
    wire        auto = pc[`PWR_AUTO_BIT];
    wire        hold = auto & pc[`PWR_DELAY_BIT] & ~clocks_ready;

    // Shadows of the control words; only host writes move them
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            lc <= `RST_LED_CTRL;
            pc <= `RST_PWR_CTRL;
        end
        else if (wr && addr == `OFS_LED_CTRL)
            lc <= wdata;
        else if (wr && addr == `OFS_PWR_CTRL)
            pc <= wdata;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence frame_seen;
        wake_frame && pc[11] && !auto && !wr;
    endsequence
    sequence no_write_2;
        !wr [*2];
    endsequence

    rdata_idle_a:
    assert property (!rd |=> rdata == 16'h0000)
        else $error("read data not zero outside a read");
    part_id_a:
    assert property (rd && addr == `OFS_PART_ID |=>
        rdata[15:1] == {FAMILY_CODE, CHIP_CODE, REV_CODE})
        else $error("identification word wrong");
    clear_read_a:
    assert property (rd && addr == `OFS_IRQ_CLEAR |=> rdata == 16'h0000)
        else $error("clear register not read as zero");
    led_off_a:
    assert property ((lc[15] && lc[9] && !wr) [*3] |->
        !port_led_3 && !port_led_0)
        else $error("led lit in unused select");
    pwr_idle_a:
    assert property ((pc[11:8] == 4'h0 && !wr) [*3] |->
        power_event_output == !pol)
        else $error("power event not idle with no enables");
    frame_event_a:
    assert property (frame_seen ##1 no_write_2 |-> power_event_output == pol)
        else $error("power event missing after wake frame");
    delay_hold_a:
    assert property ((hold && !wr) [*3] |-> power_event_output == !pol)
        else $error("power event asserted while held off");
    wake_off_a:
    assert property ((!auto && !wr) [*3] |-> !wake_to_normal)
        else $error("wake to normal without auto wake-up");
endmodule

bind global_ctrl gc_props #(
    .FAMILY_CODE(FAMILY_CODE), .CHIP_CODE(CHIP_CODE), .REV_CODE(REV_CODE)
) i_gc_props (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .wake_frame(wake_frame),
    .clocks_ready(clocks_ready), .port_led_3(port_led_3),
    .port_led_0(port_led_0), .power_event_output(power_event_output),
    .wake_to_normal(wake_to_normal)
);

// *** host_bus.sv ***
`timescale 1ns/1ps
`include "gc_regs.vh"

module host_bus
(
    // Clock
    input  wire        core_clk,
    // Register port
    output reg  [7:0]  addr,
    output reg  [15:0] wdata,
    output reg         wr,
    output reg         rd,
    input  wire [15:0] rdata
);
    initial
    begin
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end

    // Counters are the only legal table; other selects are reserved
    function [15:0] cmd(input rd_en, input [4:0] a);
        cmd = {3'b000, rd_en, `IND_TABLE_CNT, 5'b00000, a};
    endfunction

    task write(input [7:0] a, input [15:0] d);
    begin
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        wdata <= ~d;
    end
    endtask

    // Data stand only in the cycle after the strobe
    task read(input [7:0] a, output [15:0] d);
    begin
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 d = rdata;
    end
    endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
`include "gc_regs.vh"

module tb;
    localparam [7:0] FAM  = 8'h5a; // Arbitrary value
    localparam [3:0] CHIP = 4'h3;  // Arbitrary value
    localparam [2:0] REV  = 3'h2;  // Arbitrary value
    reg         core_clk = 1'b0;
    reg         rst = 1'b1;
    wire [7:0]  addr;
    wire [15:0] wdata;
    wire        wr;
    wire        rd;
    wire [15:0] rdata;
    reg         link_up, activity, full_duplex, collision, speed_100;
    reg  [31:0] count_inc;
    reg  [3:0]  ev;
    reg         clocks_ready, energy_detect_mode;
    wire        led3, led2, led1, led0, pwr, wake, irq;
    integer     n_fail = 0;
    integer     tests_run = 0;
    integer     cycles = 0;
    integer     i;
    reg  [31:0] cnt [0:31];
    reg  [15:0] d;
    reg  [4:0]  a;

    host_bus host (.core_clk(core_clk), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    global_ctrl #(.FAMILY_CODE(FAM), .CHIP_CODE(CHIP), .REV_CODE(REV),
        .WAKE_UNIT(4)) i_global_ctrl (.core_clk(core_clk), .rst(rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .link_up(link_up), .activity(activity), .full_duplex(full_duplex),
        .collision(collision), .speed_100(speed_100), .count_inc(count_inc),
        .wake_frame(ev[3]), .remote_wake(ev[2]), .link_change_up(ev[1]),
        .energy_detect(ev[0]), .clocks_ready(clocks_ready),
        .energy_detect_mode(energy_detect_mode), .port_led_3(led3),
        .port_led_2(led2), .port_led_1(led1), .port_led_0(led0),
        .power_event_output(pwr), .wake_to_normal(wake), .irq(irq));

    always #12.5 core_clk = ~core_clk;

    // The long counter run needs about 66000 cycles
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            n_fail = n_fail + 1;
            summarize;
        end
    end

    task check(input string what, input [31:0] exp, input [31:0] got);
    begin
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    task summarize;
    begin
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    task pulse(input [3:0] e);
    begin
        ev <= e;
        @(posedge core_clk);
        ev <= 4'h0;
        repeat (3) @(posedge core_clk);
    end
    endtask

    // Expected {led 3, led 0} for a select value
    function [1:0] led_exp(input [1:0] m);
        case (m)
            2'b00: led_exp = {1'b0, speed_100};
            2'b01: led_exp = {1'b0, full_duplex};
            2'b10: led_exp = {activity, speed_100};
            default: led_exp = 2'b00;
        endcase
    endfunction

    // Expected {led 2, led 1} for a select value
    function [1:0] led_mid(input [1:0] m);
        case (m)
            2'b00: led_mid = {link_up & activity, full_duplex | collision};
            2'b01: led_mid = {link_up & activity & speed_100,
                              link_up & activity & ~speed_100};
            2'b10: led_mid = {link_up, full_duplex | collision};
            default: led_mid = 2'b00;
        endcase
    endfunction

    initial
    begin
        {link_up, activity, full_duplex, collision, speed_100} = 5'h00;
        {ev, clocks_ready, energy_detect_mode} = 6'h02;
        count_inc = 32'h0000_0000;
        for (i = 0; i < 32; i = i + 1)
            cnt[i] = 32'h0000_0000;
        i = $urandom(14186);
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        host.read(`OFS_PART_ID, d);
        check("part id", {FAM, CHIP, REV}, d[15:1]);
        check("idle power event", 1'b1, pwr);
        host.read(8'h10, d);
        check("unmapped read", 16'h0000, d);
        for (i = 0; i < 4; i = i + 1)
        begin
            {link_up, activity, full_duplex, collision, speed_100} <= $urandom;
            host.write(`OFS_LED_CTRL, {i[1], 5'b00010, i[0], 9'h035});
            repeat (3) @(posedge core_clk);
            check("leds 3 and 0", led_exp(i), {led3, led0});
            check("leds 2 and 1", led_mid(i), {led2, led1});
        end
        // Counter 31 counts every cycle so its high word moves
        for (i = 0; i <= 66000; i = i + 1)
        begin
            @(posedge core_clk);
            for (a = 0; a < 31; a = a + 1)
                cnt[a] = cnt[a] + count_inc[a];
            cnt[31] = cnt[31] + count_inc[31];
            count_inc <= i < 66000 ? ($urandom | 32'h8000_0000) : 32'h0;
        end
        for (i = 0; i < 7; i = i + 1)
        begin
            a = i == 0 ? 5'd0 : i < 3 ? 5'd31 : $urandom;
            host.write(`OFS_IND_CTRL, host.cmd(1'b1, a));
            repeat (3) @(posedge core_clk);
            host.read(`OFS_IND_LOW, d);
            check("count low", cnt[a][15:0], d);
            host.read(`OFS_IND_HIGH, d);
            check("count high", cnt[a][31:16], d);
            cnt[a] = 32'h0000_0000;
        end
        host.read(`OFS_IRQ_STATUS, d);
        check("irq status", 16'h0004, d);
        host.write(`OFS_IND_LOW, 16'ha5c3);
        host.write(`OFS_IND_CTRL, host.cmd(1'b0, 5'd0));
        host.write(`OFS_IND_CTRL, host.cmd(1'b0, 5'd31));
        repeat (3) @(posedge core_clk);
        host.read(`OFS_IND_LOW, d);
        check("data after no-op", 16'ha5c3, d);
        host.write(`OFS_IRQ_ENABLE, 16'h0002);
        for (i = 0; i < 4; i = i + 1)
        begin
            host.write(`OFS_PWR_CTRL, 16'h103c | (16'h0100 << i));
            pulse(4'h1 << ((i + 1) % 4));
            check("event disabled", 1'b0, pwr);
            pulse(4'h1 << i);
            check("event enabled", 1'b1, pwr);
            check("irq raised", 1'b1, irq);
            host.read(`OFS_PWR_CTRL, d);
            check("wake status", 1'b1, d[2 + i]);
            host.write(`OFS_IRQ_ENABLE, 16'h0000);
            repeat (2) @(posedge core_clk);
            check("irq masked", 1'b0, irq);
            host.write(`OFS_IRQ_ENABLE, 16'h0002);
            host.write(`OFS_PWR_CTRL, 16'h103c | (16'h0100 << i));
            host.write(`OFS_IRQ_CLEAR, 16'h0002);
            repeat (2) @(posedge core_clk);
            check("event cleared", 1'b0, pwr);
            check("irq cleared", 1'b0, irq);
        end
        host.write(`OFS_PWR_CTRL, 16'h51bc);
        clocks_ready <= 1'b0;
        pulse(4'h1);
        check("event held", 1'b0, pwr);
        clocks_ready <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("event released", 1'b1, pwr);
        host.write(`OFS_PWR_CTRL, 16'h513c);
        clocks_ready <= 1'b0;
        pulse(4'h1);
        check("delay ignored", 1'b1, pwr);
        clocks_ready <= 1'b1;
        host.write(`OFS_PWR_CTRL, 16'h10bc);
        energy_detect_mode <= 1'b1;
        ev <= 4'h1;
        repeat (20) @(posedge core_clk);
        check("wake early", 1'b0, wake);
        repeat (30) @(posedge core_clk);
        check("wake to normal", 1'b1, wake);
        ev <= 4'h0;
        summarize;
    end
endmodule
